// ### core/i2chp_port.sv
// Two-wire host port giving word access to sixteen-bit registers.
// Functional notes
// - Acknowledge device address, register address and every data byte of a write.
// - Words travel as high byte then low byte, in writes and in reads.
// - Write bursts step the register address once per complete word.
// - Address stepping past 0xFF wraps to 0x00 and the burst continues.
// - Any number of words may be written between one start and stop.
// - Reads return high then low byte, stepping the address after each word.
// - A read without a prior address write starts at the held address.
// - The port holds the clock low while it cannot supply or take a byte.
// - Bytes are eight bits, most significant bit first.
`timescale 1ns/100ps
`include "i2chp_defines.svh"
module i2chp_port
  import i2chp_pkg::*;
#(
  parameter logic [6:0] SLAVE_SELECT_BYTE = 7'h2a
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        lclk,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             reg_wr_stb,
  output logic             reg_rd_stb,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic        reg_rd_ack,
  input  wire logic [15:0] reg_rd_data
);
  // ****************************************
  // Crossings
  // ****************************************
  i2chp_link_s lk_reg;
  i2chp_link_s lk_next;
  i2chp_host_s hs_reg;
  i2chp_host_s hs_next;
  logic        lrst;
  logic [1:0]  pin_s;
  logic        ack_s;
  logic        req_s;

  i2chp_sync2 #(.W(1)) u_rst  (.clk(lclk), .din(srst),               .dout(lrst));
  i2chp_sync2 #(.W(2)) u_pins (.clk(lclk), .din({scl_i, sda_i}),     .dout(pin_s));
  i2chp_sync2 #(.W(1)) u_ack  (.clk(lclk), .din(hs_reg.ack_tgl),     .dout(ack_s));
  i2chp_sync2 #(.W(1)) u_req  (.clk(mclk), .din(lk_reg.req_tgl),     .dout(req_s));

  function automatic logic [7:0] next_addr(input logic [7:0] a);
    return a + `I2CHP_ADDR_STEP;
  endfunction

  // ****************************************
  // Link side
  // ****************************************
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic busy_c;
  logic byte_done_c;
  logic commit_c;

  assign start_c     = pin_s[1] & lk_reg.scl_q & lk_reg.sda_q & ~pin_s[0];
  assign stop_c      = pin_s[1] & lk_reg.scl_q & ~lk_reg.sda_q & pin_s[0];
  assign rise_c      = pin_s[1] & ~lk_reg.scl_q;
  assign fall_c      = ~pin_s[1] & lk_reg.scl_q;
  assign busy_c      = lk_reg.req_tgl != ack_s;
  assign byte_done_c = fall_c & (lk_reg.bit_cnt == `I2CHP_BYTE_BITS);
  // A word is committed only once its low byte is in and the crossing is free.
  assign commit_c    = (((lk_reg.st == S_RX) & byte_done_c) | (lk_reg.st == S_HOLD))
                       & (lk_reg.idx == IDX_LO) & ~busy_c;

  always_comb
  begin
    lk_next       = lk_reg;
    lk_next.scl_q = pin_s[1];
    lk_next.sda_q = pin_s[0];
    if (start_c)
    begin
      lk_next.st      = S_DEV;
      lk_next.bit_cnt = '0;
      lk_next.sda_oe  = 1'b0;
      lk_next.scl_oe  = 1'b0;
      lk_next.pend    = 1'b0;
      lk_next.dead    = 1'b0;
    end
    else if (stop_c)
    begin
      lk_next.st     = S_IDLE;
      lk_next.sda_oe = 1'b0;
      lk_next.scl_oe = 1'b0;
    end
    else
    begin
      case (lk_reg.st)
        S_DEV, S_RX:
        begin
          if (rise_c && !lk_reg.dead)
          begin
            lk_next.shift   = {lk_reg.shift[6:0], pin_s[0]};
            lk_next.bit_cnt = lk_reg.bit_cnt + `I2CHP_CNT_STEP;
          end
          if (byte_done_c)
          begin
            lk_next.bit_cnt = '0;
            if (lk_reg.st == S_DEV)
            begin
              if (lk_reg.shift[7:1] == SLAVE_SELECT_BYTE)
              begin
                lk_next.rw     = lk_reg.shift[0];
                lk_next.idx    = IDX_REG;
                lk_next.sda_oe = 1'b1;
                lk_next.st     = S_ACK;
              end
              else
              begin
                lk_next.dead = 1'b1;
                lk_next.st   = S_IDLE;
              end
            end
            else if (lk_reg.idx == IDX_LO && busy_c)
            begin
              lk_next.scl_oe = 1'b1;
              lk_next.st     = S_HOLD;
            end
            else
            begin
              lk_next.sda_oe = 1'b1;
              lk_next.st     = S_ACK;
              if (lk_reg.idx == IDX_REG)
              begin
                lk_next.addr = lk_reg.shift;
                lk_next.idx  = IDX_HI;
              end
              else if (lk_reg.idx == IDX_HI)
              begin
                lk_next.hi  = lk_reg.shift;
                lk_next.idx = IDX_LO;
              end
            end
          end
        end
        S_HOLD:
        begin
          if (!busy_c)
          begin
            lk_next.sda_oe = 1'b1;
            lk_next.scl_oe = 1'b0;
            lk_next.st     = S_ACK;
          end
        end
        S_ACK:
        begin
          if (fall_c)
          begin
            lk_next.sda_oe  = 1'b0;
            lk_next.bit_cnt = '0;
            if (lk_reg.rw)
            begin
              lk_next.scl_oe = 1'b1;
              lk_next.st     = S_FETCH;
            end
            else
            begin
              lk_next.st = S_RX;
            end
          end
        end
        S_FETCH:
        begin
          if (!busy_c && !lk_reg.pend)
          begin
            lk_next.req_tgl   = ~lk_reg.req_tgl;
            lk_next.xfer_we   = 1'b0;
            lk_next.xfer_addr = lk_reg.addr;
            lk_next.pend      = 1'b1;
          end
          else if (!busy_c)
          begin
            lk_next.rd_word  = hs_reg.rd_hold;
            lk_next.shift    = hs_reg.rd_hold[15:8];
            lk_next.sda_oe   = ~hs_reg.rd_hold[15];
            lk_next.lo_phase = 1'b0;
            lk_next.pend     = 1'b0;
            lk_next.bit_cnt  = '0;
            lk_next.scl_oe   = 1'b0;
            lk_next.st       = S_TX;
          end
        end
        S_TX:
        begin
          if (fall_c)
          begin
            if (lk_reg.bit_cnt == `I2CHP_LAST_BIT)
            begin
              lk_next.sda_oe  = 1'b0;
              lk_next.bit_cnt = '0;
              lk_next.st      = S_MACK;
            end
            else
            begin
              lk_next.shift   = {lk_reg.shift[6:0], 1'b0};
              lk_next.sda_oe  = ~lk_reg.shift[6];
              lk_next.bit_cnt = lk_reg.bit_cnt + `I2CHP_CNT_STEP;
            end
          end
        end
        S_MACK:
        begin
          if (rise_c)
          begin
            lk_next.mack = ~pin_s[0];
          end
          if (fall_c)
          begin
            if (lk_reg.lo_phase)
            begin
              lk_next.addr = next_addr(lk_reg.addr);
            end
            if (!lk_reg.mack)
            begin
              lk_next.st = S_IDLE;
            end
            else if (!lk_reg.lo_phase)
            begin
              lk_next.shift    = lk_reg.rd_word[7:0];
              lk_next.sda_oe   = ~lk_reg.rd_word[7];
              lk_next.lo_phase = 1'b1;
              lk_next.st       = S_TX;
            end
            else
            begin
              lk_next.scl_oe = 1'b1;
              lk_next.st     = S_FETCH;
            end
          end
        end
        default:
        begin
          lk_next.st = S_IDLE;
        end
      endcase
      // Bursts have no word limit; the index simply returns to the high byte.
      if (commit_c)
      begin
        lk_next.req_tgl    = ~lk_reg.req_tgl;
        lk_next.xfer_we    = 1'b1;
        lk_next.xfer_addr  = lk_reg.addr;
        lk_next.xfer_wdata = {lk_reg.hi, lk_reg.shift};
        lk_next.addr       = next_addr(lk_reg.addr);
        lk_next.idx        = IDX_HI;
      end
    end
  end

  always_ff @(posedge lclk)
  begin
    if (lrst)
      lk_reg <= '0;
    else
      lk_reg <= lk_next;
  end

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = lk_reg.scl_oe;
  assign sda_oe = lk_reg.sda_oe;

  // ****************************************
  // Register side
  // ****************************************
  // Transfer fields are held by the link side until the toggle returns.
  always_comb
  begin
    hs_next        = hs_reg;
    hs_next.wr_stb = 1'b0;
    hs_next.rd_stb = 1'b0;
    if (req_s != hs_reg.seen && !hs_reg.wait_rd)
    begin
      hs_next.seen  = req_s;
      hs_next.addr  = lk_reg.xfer_addr;
      hs_next.wdata = lk_reg.xfer_wdata;
      if (lk_reg.xfer_we)
      begin
        hs_next.wr_stb  = 1'b1;
        hs_next.ack_tgl = ~hs_reg.ack_tgl;
      end
      else
      begin
        hs_next.rd_stb  = 1'b1;
        hs_next.wait_rd = 1'b1;
      end
    end
    if (hs_reg.wait_rd && reg_rd_ack)
    begin
      hs_next.rd_hold = reg_rd_data;
      hs_next.wait_rd = 1'b0;
      hs_next.ack_tgl = ~hs_reg.ack_tgl;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      hs_reg <= '0;
    else
      hs_reg <= hs_next;
  end

  assign reg_wr_stb = hs_reg.wr_stb;
  assign reg_rd_stb = hs_reg.rd_stb;
  assign reg_addr   = hs_reg.addr;
  assign reg_wdata  = hs_reg.wdata;

  // ****************************************
  // Checks
  // ****************************************
  AST_DEV_ACK: assert property (@(posedge lclk) disable iff (lrst)
    (lk_reg.st == S_DEV && byte_done_c && lk_reg.shift[7:1] == SLAVE_SELECT_BYTE)
    |=> lk_reg.sda_oe && lk_reg.st == S_ACK) else $error("Device byte not acknowledged.");
  AST_DATA_ACK: assert property (@(posedge lclk) disable iff (lrst)
    (lk_reg.st == S_RX && byte_done_c && !(lk_reg.idx == IDX_LO && busy_c))
    |=> lk_reg.sda_oe) else $error("Write byte not acknowledged.");
  AST_HIGH_FIRST: assert property (@(posedge lclk) disable iff (lrst)
    ($changed(lk_reg.req_tgl) && lk_reg.xfer_we)
    |-> lk_reg.xfer_wdata == {$past(lk_reg.hi), $past(lk_reg.shift)})
    else $error("Write word bytes out of order.");
  AST_WR_INC: assert property (@(posedge lclk) disable iff (lrst)
    commit_c |=> lk_reg.addr == $past(lk_reg.addr) + `I2CHP_ADDR_STEP)
    else $error("Address not stepped after written word.");
  AST_WRAP: assert property (@(posedge lclk) disable iff (lrst)
    (commit_c && lk_reg.addr == `I2CHP_ADDR_TOP) |=> lk_reg.addr == `I2CHP_ADDR_RST)
    else $error("Address did not wrap.");
  AST_RD_INC: assert property (@(posedge lclk) disable iff (lrst)
    (lk_reg.st == S_MACK && fall_c && lk_reg.lo_phase)
    |=> lk_reg.addr == $past(lk_reg.addr) + `I2CHP_ADDR_STEP)
    else $error("Address not stepped after sent word.");
  AST_RD_ADDR: assert property (@(posedge lclk) disable iff (lrst)
    ($changed(lk_reg.req_tgl) && !lk_reg.xfer_we) |-> lk_reg.xfer_addr == lk_reg.addr)
    else $error("Read fetched from wrong address.");
  AST_STRETCH: assert property (@(posedge lclk) disable iff (lrst)
    (lk_reg.st == S_FETCH && busy_c) |=> lk_reg.scl_oe)
    else $error("Clock released while waiting for data.");
  AST_MSB_FIRST: assert property (@(posedge lclk) disable iff (lrst)
    (lk_reg.st == S_TX && $past(lk_reg.st) == S_FETCH) |-> lk_reg.sda_oe == !lk_reg.rd_word[15])
    else $error("Read byte not started at its top bit.");
  AST_REG_LOAD: assert property (@(posedge lclk) disable iff (lrst)
    (lk_reg.st == S_RX && byte_done_c && lk_reg.idx == IDX_REG && !busy_c)
    |=> lk_reg.addr == $past(lk_reg.shift)) else $error("Address byte not loaded.");
  AST_WORD_ONLY: assert property (@(posedge lclk) disable iff (lrst)
    ($changed(lk_reg.req_tgl) && lk_reg.xfer_we) |-> $past(lk_reg.idx) == IDX_LO)
    else $error("Write issued without a full word.");
endmodule // i2chp_port

// ### shared/i2chp_defines.svh
// Constant names for the host register port.
`ifndef I2CHP_DEFINES_SVH
`define I2CHP_DEFINES_SVH
`define I2CHP_BYTE_BITS 4'h8
`define I2CHP_LAST_BIT  4'h7
`define I2CHP_CNT_STEP  4'h1
`define I2CHP_ADDR_STEP 8'h01
`define I2CHP_ADDR_TOP  8'hff
`define I2CHP_ADDR_RST  8'h00
`endif

// ### shared/i2chp_pkg.sv
// Types shared by the host register port.
package i2chp_pkg;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_DEV   = 3'b001,
    S_ACK   = 3'b010,
    S_RX    = 3'b011,
    S_HOLD  = 3'b100,
    S_FETCH = 3'b101,
    S_TX    = 3'b110,
    S_MACK  = 3'b111
  } i2chp_state_e;

  typedef enum logic [1:0] {
    IDX_REG = 2'b00,
    IDX_HI  = 2'b01,
    IDX_LO  = 2'b10,
    IDX_NA  = 2'b11
  } i2chp_idx_e;

  typedef struct packed {
    i2chp_state_e st;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic         rw;
    logic         dead;
    i2chp_idx_e   idx;
    logic [7:0]   hi;
    logic         lo_phase;
    logic         mack;
    logic [15:0]  rd_word;
    logic [7:0]   addr;
    logic         pend;
    logic         req_tgl;
    logic         xfer_we;
    logic [7:0]   xfer_addr;
    logic [15:0]  xfer_wdata;
    logic         scl_oe;
    logic         sda_oe;
    logic         scl_q;
    logic         sda_q;
  } i2chp_link_s;

  typedef struct packed {
    logic         seen;
    logic         ack_tgl;
    logic         wait_rd;
    logic [15:0]  rd_hold;
    logic         wr_stb;
    logic         rd_stb;
    logic [7:0]   addr;
    logic [15:0]  wdata;
  } i2chp_host_s;
endpackage

// ### core/i2chp_sync2.sv
// Two flip-flop synchroniser for levels and toggles.
`timescale 1ns/100ps
module i2chp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    meta_reg <= din;
    dout     <= meta_reg;
  end
endmodule // i2chp_sync2

// ### dv/i2chp_host_model.sv
// Behavioural two-wire bus master that clocks the host register port.
`timescale 1ns/100ps
module i2chp_host_model #(
  parameter int HALF_NS = 250
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // **********************************************************************
  // Bus idles released; both wires are pulled up outside frames.
  // **********************************************************************
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // The port may stretch the clock, so releasing it is not enough: wait for the wire.
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 100000)
    begin
      #10;
      n++;
    end
    #(HALF_NS);
  endtask

  // Data moves only HALF_NS / 2, about a fifth of a bit, after the clock falls, never near the edge.
  task automatic bit_io(input logic v, output logic r);
    sda_low = ~v;
    #(HALF_NS);
    rise();
    r = sda;
    scl_low = 1'b1;
    #(HALF_NS / 2);
  endtask

  task automatic start();
    sda_low = 1'b0;
    #(HALF_NS);
    rise();
    sda_low = 1'b1;
    #(HALF_NS);
    scl_low = 1'b1;
    #(HALF_NS / 2);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #(HALF_NS);
    rise();
    sda_low = 1'b0;
    #(HALF_NS);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule // i2chp_host_model

// ### dv/tb_i2c_host_register_port.sv
// Self-checking bench for the two-wire host register port.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_i2c_host_register_port;
  logic        mclk, lclk, srst, scl_o, scl_oe, sda_o, sda_oe;
  logic        reg_wr_stb, reg_rd_stb, reg_rd_ack;
  logic [7:0]  reg_addr, cur;
  logic [15:0] reg_wdata, reg_rd_data;
  wire         m_scl_low, m_sda_low;
  wire         scl = ~(m_scl_low | (scl_oe & ~scl_o));
  wire         sda = ~(m_sda_low | (sda_oe & ~sda_o));
  logic [24:0] exp_q[$];
  logic [24:0] note;
  logic [15:0] mem [256];
  logic [15:0] ref_m [256];
  int          n_fail, checked;

  i2chp_port #(.SLAVE_SELECT_BYTE(7'h2a)) i_i2chp_port (
    .mclk(mclk), .srst(srst), .lclk(lclk), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rd_ack(reg_rd_ack), .reg_rd_data(reg_rd_data));
  i2chp_host_model i_i2chp_host_model (.scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end

  // **********************************************************************
  // Register side: compare each strobe with the oldest note, answer reads.
  // **********************************************************************
  // Strobes are looked at mid-cycle, away from the edge that launches them.
  always @(negedge mclk)
    if (reg_wr_stb === 1'b1 || reg_rd_stb === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHK(1'b1, 1'b0)
      else
      begin
        note = exp_q.pop_front();
        `CHK({reg_wr_stb, reg_addr, reg_wdata & {16{reg_wr_stb}}}, note)
      end
      if (reg_wr_stb === 1'b1)
        mem[reg_addr] = reg_wdata;
    end

  // Answer late as well as promptly; the data is scrambled once the answer is gone.
  always @(negedge mclk)
    if (reg_rd_stb === 1'b1)
    begin
      repeat ($urandom_range(1, 12)) @(negedge mclk);
      reg_rd_ack = 1'b1;
      reg_rd_data = mem[reg_addr];
      @(negedge mclk);
      reg_rd_ack = 1'b0;
      reg_rd_data = ~reg_rd_data;
    end

  // **********************************************************************
  // Host transfers; cur is the address register the port should hold.
  // **********************************************************************
  task automatic xfer_wr(input logic [7:0] ra, input int n, input logic lone);
    logic        ack;
    logic [15:0] w;
    i_i2chp_host_model.start();
    i_i2chp_host_model.wbyte({7'h2a, 1'b0}, ack);
    `CHK(ack, 1'b1)
    i_i2chp_host_model.wbyte(ra, ack);
    `CHK(ack, 1'b1)
    cur = ra;
    for (int i = 0; i < n; i++)
    begin
      w = 16'($urandom);
      ref_m[cur] = w;
      exp_q.push_back({1'b1, cur, w});
      i_i2chp_host_model.wbyte(w[15:8], ack);
      `CHK(ack, 1'b1)
      i_i2chp_host_model.wbyte(w[7:0], ack);
      `CHK(ack, 1'b1)
      cur = cur + 8'h01;
    end
    if (lone)
      i_i2chp_host_model.wbyte(8'h5a, ack);
    i_i2chp_host_model.stop();
  endtask

  task automatic xfer_rd(input int n);
    logic       ack;
    logic [7:0] b;
    for (int i = 0; i < n; i++)
      exp_q.push_back({1'b0, cur + 8'(i), 16'h0000});
    i_i2chp_host_model.start();
    i_i2chp_host_model.wbyte({7'h2a, 1'b1}, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++)
    begin
      i_i2chp_host_model.rbyte(1'b1, b);
      `CHK(b, ref_m[cur][15:8])
      i_i2chp_host_model.rbyte(i < n - 1, b);
      `CHK(b, ref_m[cur][7:0])
      cur = cur + 8'h01;
    end
    i_i2chp_host_model.stop();
  endtask

  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    // A clean run takes about 3.5 ms; the limit keeps a hang under 100k clock cycles.
    #4800000;
    n_fail++;
    summarize();
  end

  initial
  begin
    logic       ack;
    logic [7:0] a;
    int         n;
    void'($urandom(32'h99077b7f));
    srst = 1'b1;
    reg_rd_ack = 1'b0;
    reg_rd_data = 16'h0000;
    cur = 8'h00;
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 16'($urandom);
      ref_m[i] = mem[i];
    end
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    repeat (8) @(negedge mclk);
    xfer_rd(1);
    xfer_wr(8'($urandom), 256, 1'b0);
    xfer_wr(8'hfe, 3, 1'b1);
    xfer_wr(8'hff, 0, 1'b0);
    xfer_rd(3);
    // A frame for another address must leave the port and its address register alone.
    i_i2chp_host_model.start();
    i_i2chp_host_model.wbyte({7'h15, 1'b0}, ack);
    `CHK(ack, 1'b0)
    i_i2chp_host_model.wbyte(8'h40, ack);
    i_i2chp_host_model.stop();
    xfer_rd(2);
    for (int k = 0; k < 3; k++)
    begin
      a = 8'($urandom);
      n = $urandom_range(1, 3);
      xfer_wr(a, n, 1'($urandom));
      xfer_wr(a, 0, 1'b0);
      xfer_rd(n);
    end
    repeat (20) @(negedge mclk);
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule // tb_i2c_host_register_port
